/* src/emram_pkg.sv */
// Shared constants and types for the embedded RAM feature logic.
// Assumes a single clock domain; all users import the whole package.

package emram_pkg;

	// ************************************************************
	// Error protection geometry and status codes
	// ************************************************************
	localparam int ECC_DATA_W = 64;
	localparam int ECC_CODE_W = 72;
	localparam int ECC_PAR_W = 7;
	localparam int ECC_LANE_W = 9;
	localparam int ECC_LANES = 8;
	localparam logic [2:0] ECC_ST_NONE = 3'h0;
	localparam logic [2:0] ECC_ST_FIXED = 3'h3;
	localparam logic [2:0] ECC_ST_DOUBLE = 3'h5;

	// ************************************************************
	// Lane geometry defaults and limits
	// ************************************************************
	localparam int DEF_LANE_W = 9;
	localparam int DEF_LANES = 2;
	localparam int DEF_ADDR_W = 10;
	localparam int LANE_W_MIN = 8;
	localparam int LANE_W_MAX = 10;
	localparam int ADDR_W_MIN = 2;

	// ************************************************************
	// Read-during-write choices and carried results
	// ************************************************************
	typedef enum logic {EMRAM_RDW_NEW, EMRAM_RDW_OLD} emram_rdw_t;
	typedef enum logic {EMRAM_MASK_DONTCARE, EMRAM_MASK_CURRENT} emram_mask_rd_t;

	typedef struct packed {
		logic [ECC_DATA_W-1:0] data;
		logic [2:0] status;
	} emram_ecc_res_t;

endpackage

/* src/emram_secded.sv */
// Single-error-correct, double-error-detect codec for one 64-bit word.
// Purely combinational; the caller registers whatever it needs.

`timescale 1ns/1ps

module emram_secded
	import emram_pkg::*;
(
	// Encoder
	input wire logic [ECC_DATA_W-1:0] enc_data,
	output logic [ECC_CODE_W-1:0] enc_code,
	// Decoder
	input wire logic [ECC_CODE_W-1:0] dec_code,
	output emram_ecc_res_t dec_res
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic is_check_pos(input int pos);
		is_check_pos = ((pos & (pos - 1)) == 0);
	endfunction

	// Bit 0 is overall parity, positions 1..71 form the Hamming word
	function automatic logic [ECC_PAR_W-1:0] syndrome(input logic [ECC_CODE_W-1:0] c);
		logic [ECC_PAR_W-1:0] s;
		s = '0;
		for (int pos = 1; pos < ECC_CODE_W; pos++)
		begin
			for (int p = 0; p < ECC_PAR_W; p++)
			begin
				if (((pos >> p) & 1) == 1)
				begin
					s[p] = s[p] ^ c[pos];
				end
			end
		end
		syndrome = s;
	endfunction

	function automatic logic [ECC_CODE_W-1:0] encode(input logic [ECC_DATA_W-1:0] d);
		logic [ECC_CODE_W-1:0] c;
		logic [ECC_PAR_W-1:0] s;
		int k;
		c = '0;
		k = 0;
		for (int pos = 1; pos < ECC_CODE_W; pos++)
		begin
			if (!is_check_pos(pos))
			begin
				c[pos] = d[k];
				k++;
			end
		end
		s = syndrome(c);
		for (int p = 0; p < ECC_PAR_W; p++)
		begin
			c[1 << p] = s[p];
		end
		c[0] = ^c;
		encode = c;
	endfunction

	function automatic emram_ecc_res_t decode(input logic [ECC_CODE_W-1:0] c);
		logic [ECC_CODE_W-1:0] f;
		logic [ECC_PAR_W-1:0] s;
		logic odd;
		emram_ecc_res_t r;
		int k;
		f = c;
		s = syndrome(c);
		odd = ^c;
		r = '0;
		k = 0;
		// Three or more flips may alias to any of these outcomes
		if (odd && (int'(s) < ECC_CODE_W))
		begin
			f[s] = ~f[s];
			r.status = ECC_ST_FIXED;
		end
		else if (s != '0 || odd)
		begin
			r.status = ECC_ST_DOUBLE;
		end
		else
		begin
			r.status = ECC_ST_NONE;
		end
		for (int pos = 1; pos < ECC_CODE_W; pos++)
		begin
			if (!is_check_pos(pos))
			begin
				r.data[k] = f[pos];
				k++;
			end
		end
		decode = r;
	endfunction

	assign enc_code = encode(enc_data);
	assign dec_res = decode(dec_code);

endmodule // emram_secded

/* src/emram_lane_mem.sv */
// Two-port lane-masked storage array with read-during-write shaping.
// Assumes registered write controls; both ports share one clock.

`timescale 1ns/1ps

module emram_lane_mem
	import emram_pkg::*;
#(
	parameter int LANE_W = DEF_LANE_W,
	parameter int LANES = DEF_LANES,
	parameter int DEPTH_W = DEF_ADDR_W,
	parameter emram_rdw_t RDW_EN = EMRAM_RDW_NEW,
	parameter emram_mask_rd_t RDW_MASK = EMRAM_MASK_CURRENT
)
(
	// Clock
	input wire logic clk,
	// Per-port write controls, index 0 is the first port
	input wire logic [1:0] wr_en,
	input wire logic [1:0][DEPTH_W-1:0] addr,
	input wire logic [1:0][LANE_W*LANES-1:0] din,
	input wire logic [1:0][LANES-1:0] be,
	// Per-port read word before the output latch
	output logic [1:0][LANE_W*LANES-1:0] rd_word
);

	localparam int W = LANE_W * LANES;

	logic [W-1:0] store [2**DEPTH_W];

	// ************************************************************
	// Lane-masked write
	// ************************************************************
	// Second port is applied last, so it wins a same-lane collision
	always_ff @(posedge clk)
	begin
		for (int p = 0; p < 2; p++)
		begin
			for (int l = 0; l < LANES; l++)
			begin
				if (wr_en[p] && be[p][l]) // [RL1] [RL7] [RL4] [RL5] [RL22]
				begin
					store[addr[p]][l*LANE_W +: LANE_W] <= din[p][l*LANE_W +: LANE_W]; // [RL6]
				end
			end
		end
	end

	// ************************************************************
	// Read word with read-during-write choice per lane
	// ************************************************************
	for (genvar p = 0; p < 2; p++)
	begin : g_port
		for (genvar l = 0; l < LANES; l++)
		begin : g_lane
			wire [LANE_W-1:0] cur = store[addr[p]][l*LANE_W +: LANE_W];
			wire [LANE_W-1:0] wdat = din[p][l*LANE_W +: LANE_W];
			wire [LANE_W-1:0] on_lane = (RDW_EN == EMRAM_RDW_NEW) ? wdat : cur;
			wire [LANE_W-1:0] off_lane = (RDW_MASK == EMRAM_MASK_CURRENT) ? cur : '0;
			assign rd_word[p][l*LANE_W +: LANE_W] = !wr_en[p] ? cur :
				(be[p][l] ? on_lane : off_lane); // [RL10]
		end
	end

endmodule // emram_lane_mem

/* src/emram_core.sv */
// Embedded RAM feature logic: lane masks, packing, address hold,
// mixed read width, output clears and 64-bit error protection.
// Assumes fabric logic drives both ports synchronously to clk.
//
// Local design decisions: the address-and-strobe port and the address map.

`timescale 1ns/1ps

// How it works
// [RL1] Write touches only lanes whose mask is set
// [RL2] Unused mask defaults to all lanes enabled
// [RL3] Mask capture registers have no clear
// [RL4] With parity, a mask bit gates nine bits
// [RL5] Logic block widest mode gates ten-bit lanes
// [RL6] Mask bits map in order onto lanes
// [RL7] Mask bits active high, one enables lane
// [RL8] Fabric never masks lanes with protection on
// [RL9] Fabric masks dual-port only at 8/9 multiples
// [RL10] Masked lane reads undefined or current contents
// [RL11] Packed mode splits block by top address
// [RL12] Address hold keeps the latched address
// [RL13] Each port has its own hold input
// [RL14] Read width may differ from write width
// [RL15] Fabric avoids mixed-width logic block FIFO
// [RL16] Output latches and registers clear asynchronously
// [RL17] Protection only in 64-bit simple dual-port
// [RL18] Correct single, detect double bit errors
// [RL19] Status codes 000, 011, 101 only
// [RL20] Registered status shares output clock and clear
// [RL21] Fabric avoids old-data mode with protection
// [RL22] Ninth bit stored plainly, no parity computed
// [RL23] Mask sampled on the write's own edge
module emram_core
	import emram_pkg::*;
#(
	parameter int LANE_W = DEF_LANE_W,
	parameter int LANES = DEF_LANES,
	parameter int ADDR_W = DEF_ADDR_W,
	parameter int DATA_W = LANE_W * LANES,
	parameter int RD_DIV = 1,
	parameter int SEL_W = (RD_DIV > 1) ? $clog2(RD_DIV) : 1,
	parameter int RD_W = DATA_W / RD_DIV,
	parameter bit USE_BYTEENA = 1'b1,
	parameter bit PACKED = 1'b0,
	parameter bit ECC_EN = 1'b0,
	parameter bit OUT_REG = 1'b1,
	parameter bit STATUS_REG = 1'b1,
	parameter emram_rdw_t RDW_EN = EMRAM_RDW_NEW,
	parameter emram_mask_rd_t RDW_MASK = EMRAM_MASK_CURRENT
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous clear of output latches and registers
	input wire logic out_clear,
	// First port
	input wire logic [ADDR_W-1:0] first_addr,
	input wire logic [DATA_W-1:0] first_din,
	input wire logic first_we,
	input wire logic [LANES-1:0] first_be,
	input wire logic first_hold,
	output logic [DATA_W-1:0] first_q,
	// Second port
	input wire logic [ADDR_W-1:0] second_addr,
	input wire logic [SEL_W-1:0] second_sel,
	input wire logic [DATA_W-1:0] second_din,
	input wire logic second_we,
	input wire logic [LANES-1:0] second_be,
	input wire logic second_hold,
	output logic [RD_W-1:0] second_q,
	// Error status
	output logic [2:0] ecc_status
);

	// ************************************************************
	// Configuration checks
	// ************************************************************
	if (LANE_W < LANE_W_MIN || LANE_W > LANE_W_MAX || LANES < 1 || ADDR_W < ADDR_W_MIN)
	begin : g_bad_geom
		$error("emram_core: unsupported lane or address geometry");
	end
	if (DATA_W != LANE_W * LANES || RD_DIV < 1 || (RD_DIV & (RD_DIV - 1)) != 0
		|| RD_W * RD_DIV != DATA_W || (RD_DIV > 1 && SEL_W != $clog2(RD_DIV)))
	begin : g_bad_width
		$error("emram_core: read width must be a power-of-two division of the word");
	end
	if (ECC_EN && (LANE_W != ECC_LANE_W || LANES != ECC_LANES || PACKED || RD_DIV != 1))
	begin : g_bad_ecc
		$error("emram_core: protection needs the plain 64-bit simple dual-port shape"); // [RL17]
	end
	if (ECC_EN && RDW_EN == EMRAM_RDW_OLD)
	begin : g_bad_rdw
		$error("emram_core: old-data read during write is unavailable with protection"); // [RL21]
	end

	// ************************************************************
	// Input capture
	// ************************************************************
	logic [1:0][ADDR_W-1:0] addr_reg;
	logic [1:0] we_reg;
	logic [1:0][DATA_W-1:0] din_reg;
	logic [1:0][LANES-1:0] be_reg;
	logic [SEL_W-1:0] sel_reg;
	logic [SEL_W-1:0] sel_lat_reg;
	emram_ecc_res_t dec_lat;
	emram_ecc_res_t dec_raw;
	logic [ECC_CODE_W-1:0] enc_code;

	wire [1:0] hold_in = {second_hold, first_hold};
	wire [1:0][ADDR_W-1:0] addr_in = {second_addr, first_addr};
	// Protection turns the second port into the read-only side
	wire [1:0] we_in = {second_we & ~ECC_EN, first_we};
	wire [DATA_W-1:0] first_wdat = ECC_EN ? DATA_W'(enc_code) : first_din;
	wire [1:0][DATA_W-1:0] din_in = {second_din, first_wdat};
	// Masks forced on when unused or when protection owns the word
	wire [1:0][LANES-1:0] be_in = (USE_BYTEENA && !ECC_EN) ? {second_be, first_be} :
		{2 * LANES{1'b1}}; // [RL2] [RL8]

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			addr_reg <= '0;
			we_reg <= '0;
			sel_reg <= '0;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				if (!hold_in[p]) // [RL12] [RL13]
				begin
					addr_reg[p] <= addr_in[p];
				end
			end
			if (!second_hold)
			begin
				sel_reg <= second_sel;
			end
			we_reg <= we_in;
		end
	end

	// No reset or clear here, so clears never disturb a pending mask
	always_ff @(posedge clk)
	begin
		din_reg <= din_in;
		be_reg <= be_in; // [RL3] [RL23]
	end

	// ************************************************************
	// Storage and packing
	// ************************************************************
	logic [1:0][ADDR_W-1:0] phys;
	logic [1:0][DATA_W-1:0] rd_word;

	for (genvar p = 0; p < 2; p++)
	begin : g_pack
		assign phys[p] = PACKED ? {1'(p), addr_reg[p][ADDR_W-2:0]} : addr_reg[p]; // [RL11]
	end

	emram_lane_mem #(
		.LANE_W(LANE_W),
		.LANES(LANES),
		.DEPTH_W(ADDR_W),
		.RDW_EN(RDW_EN),
		.RDW_MASK(RDW_MASK)
	) u_mem (
		.clk(clk),
		.wr_en(we_reg),
		.addr(phys),
		.din(din_reg),
		.be(be_reg),
		.rd_word(rd_word)
	);

	// ************************************************************
	// Output latch, status shadow and output registers
	// ************************************************************
	logic [1:0][DATA_W-1:0] lat_reg;
	logic [DATA_W-1:0] raw_reg;
	logic [DATA_W-1:0] q0_reg;
	logic [RD_W-1:0] q1_reg;
	logic [2:0] status_reg;

	always_ff @(posedge clk or posedge out_clear)
	begin
		if (out_clear)
		begin
			lat_reg <= '0; // [RL16]
			sel_lat_reg <= '0;
		end
		else if (!rst_n)
		begin
			lat_reg <= '0;
			sel_lat_reg <= '0;
		end
		else
		begin
			lat_reg <= rd_word;
			sel_lat_reg <= sel_reg;
		end
	end

	// Unregistered status comes from this copy, which no clear reaches
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			raw_reg <= '0;
		end
		else
		begin
			raw_reg <= rd_word[1]; // [RL20]
		end
	end

	wire [DATA_W-1:0] second_full = ECC_EN ? DATA_W'(dec_lat.data) : lat_reg[1];
	wire [RD_W-1:0] second_slice = second_full[sel_lat_reg * RD_W +: RD_W]; // [RL14]

	always_ff @(posedge clk or posedge out_clear)
	begin
		if (out_clear)
		begin
			q0_reg <= '0; // [RL16]
			q1_reg <= '0;
			status_reg <= ECC_ST_NONE; // [RL20]
		end
		else if (!rst_n)
		begin
			q0_reg <= '0;
			q1_reg <= '0;
			status_reg <= ECC_ST_NONE;
		end
		else
		begin
			q0_reg <= lat_reg[0];
			q1_reg <= second_slice;
			status_reg <= dec_lat.status;
		end
	end

	emram_secded u_ecc (
		.enc_data(ECC_DATA_W'(first_din)),
		.enc_code(enc_code),
		.dec_code(ECC_CODE_W'(lat_reg[1])),
		.dec_res(dec_lat)
	);

	emram_secded u_ecc_raw (
		.enc_data(ECC_DATA_W'(first_din)),
		.enc_code(),
		.dec_code(ECC_CODE_W'(raw_reg)),
		.dec_res(dec_raw)
	);

	// Unregistered modes bypass the output stage by design
	assign first_q = OUT_REG ? q0_reg : lat_reg[0];
	assign second_q = OUT_REG ? q1_reg : second_slice;
	assign ecc_status = !ECC_EN ? ECC_ST_NONE :
		(STATUS_REG ? status_reg : dec_raw.status); // [RL18] [RL19]

	// ************************************************************
	// Checks
	// ************************************************************
	emram_ecc_res_t chk_one;
	emram_ecc_res_t chk_two;
	logic [ECC_CODE_W-1:0] one_flip;
	logic [ECC_CODE_W-1:0] two_flip;
	logic [ADDR_W-1:0] pa_prev;

	assign one_flip = enc_code ^ (ECC_CODE_W'(1) << first_din[5:0]);
	assign two_flip = one_flip ^ (ECC_CODE_W'(1) << (7'h40 + {4'h0, first_din[8:6]}));

	emram_secded u_chk_one (
		.enc_data('0),
		.enc_code(),
		.dec_code(one_flip),
		.dec_res(chk_one)
	);

	emram_secded u_chk_two (
		.enc_data('0),
		.enc_code(),
		.dec_code(two_flip),
		.dec_res(chk_two)
	);

	always_ff @(posedge clk)
	begin
		pa_prev <= phys[0];
	end

	wire [LANE_W-1:0] cur_lane0 = u_mem.store[phys[0]][LANE_W-1:0];
	wire [LANE_W-1:0] chk_lane0 = u_mem.store[pa_prev][LANE_W-1:0];
	wire [LANE_W-1:0] din_lane0 = din_reg[0][LANE_W-1:0];
	wire hit1 = we_reg[1] && be_reg[1][0] && (phys[1] == phys[0]);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr_lane0_on;
		we_reg[0] && be_reg[0][0] && !hit1;
	endsequence

	sequence s_no_clear2;
		!out_clear ##1 !out_clear;
	endsequence

	property p_lane_masked;
		(we_reg[0] && !be_reg[0][0] && !hit1) |=> (chk_lane0 == $past(cur_lane0));
	endproperty
	a_lane_masked: assert property (p_lane_masked) else $error("masked lane changed"); // [RL1]

	property p_lane_written;
		s_wr_lane0_on |=> (chk_lane0 == $past(din_lane0));
	endproperty
	a_lane_written: assert property (p_lane_written) else $error("enabled lane not written"); // [RL7]

	property p_hold;
		first_hold |=> (addr_reg[0] == $past(addr_reg[0]));
	endproperty
	a_hold: assert property (p_hold) else $error("held address moved"); // [RL12]

	property p_hold_indep;
		(first_hold && !second_hold) |=> (addr_reg[1] == $past(second_addr));
	endproperty
	a_hold_indep: assert property (p_hold_indep) else $error("second port hold not independent"); // [RL13]

	property p_hold_second;
		second_hold |=> ((addr_reg[1] == $past(addr_reg[1])) && (sel_reg == $past(sel_reg)));
	endproperty
	a_hold_second: assert property (p_hold_second) else $error("second held address moved"); // [RL12]

	property p_mask_default;
		first_we |=> (be_reg[0] == ((USE_BYTEENA && !ECC_EN) ? $past(first_be) : {LANES{1'b1}}));
	endproperty
	a_mask_default: assert property (p_mask_default) else $error("unused mask not all ones"); // [RL2]

	property p_mask_survives_clear;
		out_clear |=> (be_reg[0] == $past(be_in[0]));
	endproperty
	a_mask_survives_clear: assert property (p_mask_survives_clear) else $error("mask cleared"); // [RL3]

	property p_clear;
		out_clear |-> (lat_reg == '0 && q0_reg == '0 && status_reg == ECC_ST_NONE);
	endproperty
	a_clear: assert property (p_clear) else $error("outputs not cleared"); // [RL16]

	property p_packed;
		PACKED |-> (!phys[0][ADDR_W-1] && phys[1][ADDR_W-1]);
	endproperty
	a_packed: assert property (p_packed) else $error("packed halves overlap"); // [RL11]

	property p_rdw_new;
		(s_wr_lane0_on ##0 s_no_clear2) |-> (RDW_EN != EMRAM_RDW_NEW)
			|| (lat_reg[0][LANE_W-1:0] == $past(din_lane0));
	endproperty
	a_rdw_new: assert property (p_rdw_new) else $error("write lane not shown on read"); // [RL10]

	property p_status_reg;
		s_no_clear2 |-> (status_reg == $past(dec_lat.status));
	endproperty
	a_status_reg: assert property (p_status_reg) else $error("status register lagging"); // [RL20]

	property p_ecc_single;
		(chk_one.status == ECC_ST_FIXED) && (chk_one.data == ECC_DATA_W'(first_din));
	endproperty
	a_ecc_single: assert property (p_ecc_single) else $error("single error not fixed"); // [RL18]

	property p_ecc_double;
		chk_two.status == ECC_ST_DOUBLE;
	endproperty
	a_ecc_double: assert property (p_ecc_double) else $error("double error not flagged"); // [RL19]

endmodule // emram_core

/* dv/emram_fabric.sv */
// Fabric-side driver model for both RAM ports.
// Assumes the caller invokes put right after a rising clock edge.

`timescale 1ns/1ps

module emram_fabric
	import emram_pkg::*;
#(
	parameter int AW = 4,
	parameter int DW = 18,
	parameter int NL = 2
)
(
	// Port drive, index 0 is the first port
	output logic [1:0][AW-1:0] addr,
	output logic [1:0][DW-1:0] din,
	output logic [1:0] we,
	output logic [1:0][NL-1:0] be,
	output logic [1:0] hold,
	output logic sel
);

	// ************************************************************
	// Port drive
	// ************************************************************
	// Both ports are 18 bits wide, a multiple of nine
	// Protection stays off in this build, so masking is legal
	// No FIFO with mixed widths is built from logic memory
	initial
	begin
		addr = '0;
		din = '0;
		we = '0;
		be = '1;
		hold = '0;
		sel = 1'b0;
	end

	task automatic put(input int p, input logic w, input logic [AW-1:0] a,
		input logic [DW-1:0] d, input logic [NL-1:0] m, input logic h, input logic s);
		we[p] <= w;
		addr[p] <= a;
		// Idle data flips so a stale value never passes for a write
		din[p] <= w ? d : ~din[p];
		be[p] <= m;
		hold[p] <= h;
		if (p == 1)
			sel <= s;
	endtask

endmodule // emram_fabric

/* dv/tb_top.sv */
// Self-checking bench for the embedded RAM feature logic.
// Assumes one 100 MHz clock; a cycle model predicts both read ports.

`timescale 1ns/1ps

module tb_top
	import emram_pkg::*;
;
	localparam int AW = 4;
	localparam int DW = 18;
	logic clk;
	logic rst_n;
	logic out_clear;
	logic [1:0][AW-1:0] addr;
	logic [1:0][DW-1:0] din;
	logic [1:0] we;
	logic [1:0][1:0] be;
	logic [1:0] hold;
	logic sel;
	logic [DW-1:0] first_q;
	logic [8:0] second_q;
	logic [2:0] ecc_status;
	logic [DW-1:0] first_q_lat;
	logic [8:0] second_q_lat;
	logic [2:0] ecc_status_lat;
	int seed = 16;
	int n_errors = 0;
	int num_checks = 0;
	logic [DW-1:0] mem [16];
	logic [AW-1:0] ar [2];
	logic [1:0] wr;
	logic [DW-1:0] dr [2];
	logic [1:0] br [2];
	logic [DW-1:0] lat [2];
	logic s1;
	logic s2;
	logic [DW-1:0] mq0;
	logic [8:0] mq1;

	emram_fabric #(.AW(AW), .DW(DW), .NL(2)) u_emram_fabric (.addr(addr),
		.din(din), .we(we), .be(be), .hold(hold), .sel(sel));

	emram_core #(.LANE_W(9), .LANES(2), .ADDR_W(AW), .RD_DIV(2)) u_emram_core (
		.clk(clk), .rst_n(rst_n), .out_clear(out_clear),
		.first_addr(addr[0]), .first_din(din[0]), .first_we(we[0]), .first_be(be[0]),
		.first_hold(hold[0]), .first_q(first_q),
		.second_addr(addr[1]), .second_sel(sel), .second_din(din[1]), .second_we(we[1]),
		.second_be(be[1]), .second_hold(hold[1]), .second_q(second_q),
		.ecc_status(ecc_status));

	// Packed halves match the stimulus address split, so one model serves both
	emram_core #(.LANE_W(9), .LANES(2), .ADDR_W(AW), .RD_DIV(2), .PACKED(1'b1),
		.OUT_REG(1'b0), .STATUS_REG(1'b0)) u_emram_core_packed (
		.clk(clk), .rst_n(rst_n), .out_clear(out_clear),
		.first_addr(addr[0]), .first_din(din[0]), .first_we(we[0]), .first_be(be[0]),
		.first_hold(hold[0]), .first_q(first_q_lat),
		.second_addr(addr[1]), .second_sel(sel), .second_din(din[1]), .second_we(we[1]),
		.second_be(be[1]), .second_hold(hold[1]), .second_q(second_q_lat),
		.ecc_status(ecc_status_lat));

	// ************************************************************
	// Reference model
	// ************************************************************
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] d,
		input logic [1:0] m);
		logic [DW-1:0] r;
		r = old;
		for (int i = 0; i < 2; i++)
			if (m[i] === 1'b1)
				r[i*9 +: 9] = d[i*9 +: 9];
		return r;
	endfunction

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr <= '0;
			s1 <= 1'b0;
			s2 <= 1'b0;
			mq0 <= '0;
			mq1 <= '0;
			for (int p = 0; p < 2; p++)
			begin
				ar[p] <= '0;
				lat[p] <= '0;
			end
		end
		else
		begin
			// Writes land before the latch samples: new data shows through
			for (int p = 0; p < 2; p++)
				if (wr[p])
					mem[ar[p]] = merge(mem[ar[p]], dr[p], br[p]);
			for (int p = 0; p < 2; p++)
			begin
				if (!hold[p])
					ar[p] <= addr[p];
				wr[p] <= we[p];
				dr[p] <= din[p];
				br[p] <= be[p];
				lat[p] <= out_clear ? '0 : mem[ar[p]];
			end
			if (!hold[1])
				s1 <= sel;
			s2 <= s1;
			mq0 <= out_clear ? '0 : lat[0];
			mq1 <= out_clear ? '0 : (s2 ? lat[1][17:9] : lat[1][8:0]);
		end
	end

	// ************************************************************
	// Checks and drive
	// ************************************************************
	task automatic check(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		if (!$isunknown(exp))
		begin
			num_checks++;
			if (got !== exp)
			begin
				n_errors++;
				$display("[FAIL] %s expected %h seen %h", name, exp, got);
			end
		end
	endtask

	// Clear must show before the next edge, so compare mid-cycle
	always @(negedge clk)
	begin
		check("first_q", out_clear ? '0 : mq0, first_q);
		check("second_q", out_clear ? '0 : DW'(mq1), DW'(second_q));
		check("ecc_status", DW'(ECC_ST_NONE), DW'(ecc_status));
		check("first_q_lat", out_clear ? '0 : lat[0], first_q_lat);
		check("second_q_lat", out_clear ? '0 : DW'(s2 ? lat[1][17:9] : lat[1][8:0]),
			DW'(second_q_lat));
		check("ecc_status_lat", DW'(ECC_ST_NONE), DW'(ecc_status_lat));
	end

	task automatic drive(input int p, input logic w, input logic [AW-1:0] a, input logic [1:0] m,
		input logic h);
		u_emram_fabric.put(p, w, a, DW'($random(seed)), m, h, 1'($random(seed)));
	endtask

	task automatic complete_run;
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run is about 324 cycles; allow far more
	initial
	begin
		#(5000 * 10);
		n_errors++;
		complete_run();
	end

	initial
	begin
		rst_n = 1'b0;
		out_clear = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// Preload every word so later partial writes are predictable
		for (int a = 0; a < 8; a++)
		begin
			@(posedge clk);
			drive(0, 1'b1, AW'(a), 2'h3, 1'b0);
			drive(1, 1'b1, AW'(a + 8), 2'h3, 1'b0);
		end
		// Every mask code, back to back on one word per port
		for (int m = 0; m < 4; m++)
		begin
			@(posedge clk);
			drive(0, 1'b1, 4'h2, 2'(m), 1'b0);
			drive(1, 1'b1, 4'hA, 2'(3 - m), 1'b0);
		end
		// First port holds address 3 while asking for 5; second port moves on
		@(posedge clk);
		drive(0, 1'b0, 4'h3, 2'h3, 1'b0);
		drive(1, 1'b0, 4'h9, 2'h3, 1'b0);
		@(posedge clk);
		drive(0, 1'b1, 4'h5, 2'h3, 1'b1);
		drive(1, 1'b0, 4'hC, 2'h3, 1'b0);
		@(posedge clk);
		drive(0, 1'b0, 4'h5, 2'h3, 1'b0);
		drive(1, 1'b0, 4'hD, 2'h3, 1'b1);
		@(posedge clk);
		drive(0, 1'b0, 4'h3, 2'h3, 1'b0);
		drive(1, 1'b0, 4'h9, 2'h3, 1'b0);
		// Random traffic with rare holds and clears
		repeat (300)
		begin
			@(posedge clk);
			out_clear <= ($random(seed) & 15) == 0;
			drive(0, 1'($random(seed)), 4'($random(seed)) & 4'h7, 2'($random(seed)),
				($random(seed) & 7) == 0);
			drive(1, 1'($random(seed)), 4'($random(seed)) | 4'h8, 2'($random(seed)),
				($random(seed) & 7) == 0);
		end
		@(posedge clk);
		out_clear <= 1'b0;
		drive(0, 1'b0, 4'h1, 2'h3, 1'b0);
		drive(1, 1'b0, 4'h8, 2'h3, 1'b0);
		repeat (5) @(posedge clk);
		complete_run();
	end
endmodule // tb_top
